// File: acec_top.sv
// analog compare event control: register, synchroniser, edge event, routing
`timescale 1ns/1ps
module acec_top (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // analog front end
  input wire logic cmp_raw_in,
  output logic analog_enable_out,
  output logic reference_select_out,
  // power mode
  input wire acec_pkg::acec_pmode_t pmode_in,
  // timer and pin
  input wire logic timer_pin_in,
  output logic capture_in_out,
  output logic timer_pin_avail_out,
  output logic comparator_output_pin_out,
  output logic comparator_output_oe_out,
  // interrupt and wake
  output logic irq_out,
  output logic wake_out
);
  acec_pkg::acec_bus_req_t req;
  acec_pkg::acec_ctrl_t ctrl_r;
  logic flag_r;
  logic route_r;
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic outval;
  logic powered_down;
  logic edge_evt;
  logic clr_flag;
  logic [7:0] rd_nxt;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  // stop2/stop1 remove power: hold everything except the read data at reset
  assign powered_down = (pmode_in == acec_pkg::PM_STOP2) ||
                        (pmode_in == acec_pkg::PM_STOP1);

  // edge match for the selected mode
  function automatic logic edge_match(input logic [1:0] mode, input logic prev,
                                      input logic cur);
    case (mode)
      acec_pkg::MODE_RISE: edge_match = !prev && cur;
      acec_pkg::MODE_BOTH: edge_match = prev != cur;
      acec_pkg::MODE_FALL0, acec_pkg::MODE_FALL2: edge_match = prev && !cur;
      default: edge_match = 1'b0;
    endcase
  endfunction

  // register write decode, shared by every writable field
  function automatic logic reg_wr_hit(input acec_pkg::acec_bus_req_t r,
                                      input logic [3:0] off);
    reg_wr_hit = r.wr && (r.addr == off);
  endfunction

  // modes from which a pending interrupt wakes the processor
  function automatic logic wake_mode(input acec_pkg::acec_pmode_t pm);
    wake_mode = (pm == acec_pkg::PM_WAIT) || (pm == acec_pkg::PM_STOP3);
  endfunction

  // control fields; same behaviour in run, wait, stop3 and debug
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || powered_down) begin
      ctrl_r <= '0;
    end else if (reg_wr_hit(req, acec_pkg::STATCTRL_OFF)) begin
      ctrl_r.enable <= req.wdata[acec_pkg::BIT_ENABLE];
      ctrl_r.refsel <= req.wdata[acec_pkg::BIT_REFSEL];
      ctrl_r.irqen <= req.wdata[acec_pkg::BIT_IRQEN];
      ctrl_r.pinen <= req.wdata[acec_pkg::BIT_PINEN];
      ctrl_r.mode <= req.wdata[acec_pkg::MODE_HI:acec_pkg::MODE_LO];
    end
  end

  // system option: route-to-capture
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || powered_down) begin
      route_r <= 1'b0;
    end else if (reg_wr_hit(req, acec_pkg::SYSOPT_OFF)) begin
      route_r <= req.wdata[acec_pkg::BIT_ROUTE];
    end
  end

  // two-stage synchroniser; raw input already high when plus exceeds minus
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || powered_down) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= cmp_raw_in;
      sync2_r <= sync1_r;
    end
  end

  assign outval = ctrl_r.enable & sync2_r;

  // previous synchronised value; follows the input even while disabled
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || powered_down) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= sync2_r;
    end
  end

  // enable toggles alone never look like an edge
  assign edge_evt = ctrl_r.enable &&
                    edge_match(ctrl_r.mode, prev_r, sync2_r);
  assign clr_flag = reg_wr_hit(req, acec_pkg::STATCTRL_OFF) &&
                    req.wdata[acec_pkg::BIT_FLAG];

  // event flag: set wins over clear
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || powered_down) begin
      flag_r <= 1'b0;
    end else if (edge_evt) begin
      flag_r <= 1'b1;
    end else if (clr_flag) begin
      flag_r <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    rd_nxt = acec_pkg::UNMAPPED_RD;
    case (req.addr)
      acec_pkg::STATCTRL_OFF: begin
        rd_nxt[acec_pkg::BIT_ENABLE] = ctrl_r.enable;
        rd_nxt[acec_pkg::BIT_REFSEL] = ctrl_r.refsel;
        rd_nxt[acec_pkg::BIT_FLAG] = flag_r;
        rd_nxt[acec_pkg::BIT_IRQEN] = ctrl_r.irqen;
        rd_nxt[acec_pkg::BIT_OUTVAL] = outval;
        rd_nxt[acec_pkg::BIT_PINEN] = ctrl_r.pinen;
        rd_nxt[acec_pkg::MODE_HI:acec_pkg::MODE_LO] = ctrl_r.mode;
      end
      acec_pkg::SYSOPT_OFF: rd_nxt[acec_pkg::BIT_ROUTE] = route_r;
      acec_pkg::PWRMODE_OFF: rd_nxt[2:0] = pmode_in;
      default: rd_nxt = acec_pkg::UNMAPPED_RD;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rdata_out <= acec_pkg::UNMAPPED_RD;
    end else if (req.rd) begin
      rdata_out <= rd_nxt;
    end else begin
      rdata_out <= acec_pkg::UNMAPPED_RD;
    end
  end

  // analog enable
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || powered_down) begin
      analog_enable_out <= 1'b0;
    end else begin
      analog_enable_out <= ctrl_r.enable;
    end
  end

  // reference select
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || powered_down) begin
      reference_select_out <= 1'b0;
    end else begin
      reference_select_out <= ctrl_r.refsel;
    end
  end

  // output pin value, low while the pin is not enabled
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || powered_down) begin
      comparator_output_pin_out <= 1'b0;
    end else begin
      comparator_output_pin_out <= ctrl_r.pinen & outval;
    end
  end

  // output pin enable
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || powered_down) begin
      comparator_output_oe_out <= 1'b0;
    end else begin
      comparator_output_oe_out <= ctrl_r.pinen;
    end
  end

  // timer capture source
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || powered_down) begin
      capture_in_out <= 1'b0;
    end else begin
      capture_in_out <= route_r ? outval : timer_pin_in;
    end
  end

  // timer pin free only while not routed
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || powered_down) begin
      timer_pin_avail_out <= 1'b1;
    end else begin
      timer_pin_avail_out <= !route_r;
    end
  end

  // interrupt request level
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || powered_down) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= ctrl_r.irqen & flag_r;
    end
  end

  // wake request from wait or stop3
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || powered_down) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= ctrl_r.irqen & flag_r & wake_mode(pmode_in);
    end
  end
endmodule

// File: acec_pkg.sv
// package for the analog compare event control block
package acec_pkg;
  // register map
  localparam logic [3:0] STATCTRL_OFF = 4'h0;
  localparam logic [3:0] SYSOPT_OFF = 4'h1;
  localparam logic [3:0] PWRMODE_OFF = 4'h2;
  // status/control field positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_REFSEL = 6;
  localparam int BIT_FLAG = 5;
  localparam int BIT_IRQEN = 4;
  localparam int BIT_OUTVAL = 3;
  localparam int BIT_PINEN = 2;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;
  // system option field position
  localparam int BIT_ROUTE = 0;
  // reset values
  localparam logic [7:0] STATCTRL_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  // edge mode codes
  localparam logic [1:0] MODE_FALL0 = 2'h0;
  localparam logic [1:0] MODE_RISE = 2'h1;
  localparam logic [1:0] MODE_FALL2 = 2'h2;
  localparam logic [1:0] MODE_BOTH = 2'h3;

  // power mode codes
  typedef enum logic [2:0] {
    PM_RUN = 3'h0,
    PM_WAIT = 3'h1,
    PM_STOP3 = 3'h2,
    PM_STOP2 = 3'h3,
    PM_STOP1 = 3'h4,
    PM_BDM = 3'h5
  } acec_pmode_t;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acec_bus_req_t;

  // control fields
  typedef struct packed {
    logic enable;
    logic refsel;
    logic irqen;
    logic pinen;
    logic [1:0] mode;
  } acec_ctrl_t;
endpackage

// File: acec_props.sv
// port checker for the analog compare event control block
`timescale 1ns/1ps
module acec_props (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  // pins
  input wire logic timer_pin_in,
  input wire acec_pkg::acec_pmode_t pmode_in,
  input wire logic analog_enable_out,
  input wire logic reference_select_out,
  input wire logic capture_in_out,
  input wire logic timer_pin_avail_out,
  input wire logic comparator_output_pin_out,
  input wire logic comparator_output_oe_out,
  input wire logic irq_out,
  input wire logic wake_out
);
  logic live_r;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  always_ff @(posedge clk_sys_in) begin
    live_r <= nrst_in && pmode_in < acec_pkg::PM_STOP2;
  end
  property ctl_copy_p;
    logic [1:0] v;
    (wr_in && addr_in == acec_pkg::STATCTRL_OFF && pmode_in == acec_pkg::PM_RUN,
     v = wdata_in[7:6]) ##1 (pmode_in != acec_pkg::PM_STOP2 && pmode_in != acec_pkg::PM_STOP1)
    |-> ##1 {analog_enable_out, reference_select_out} == v;
  endproperty
  ctl_write_a: assert property (ctl_copy_p)
    else $error("control copy wrong");
  pin_gate_a: assert property (!comparator_output_oe_out |-> !comparator_output_pin_out)
    else $error("pin driven while off");
  dis_out_a: assert property (!analog_enable_out [*3] |-> !comparator_output_pin_out)
    else $error("output high while disabled");
  route_off_a: assert property (wr_in && addr_in == acec_pkg::SYSOPT_OFF && wdata_in[0]
    && pmode_in == acec_pkg::PM_RUN |-> ##[1:2] !timer_pin_avail_out) else $error("pin still free");
  capture_a: assert property (live_r && timer_pin_avail_out |->
    capture_in_out == $past(timer_pin_in)) else $error("capture source wrong");
  wake_a: assert property (wake_out |-> $past(pmode_in) inside {acec_pkg::PM_WAIT,
    acec_pkg::PM_STOP3}) else $error("wake outside wait or stop3");
  stop_off_a: assert property (pmode_in == acec_pkg::PM_STOP2 |=> !analog_enable_out
    && !irq_out && timer_pin_avail_out) else $error("state kept in stop2");
  irq_off_a: assert property (wr_in && addr_in == acec_pkg::STATCTRL_OFF && !wdata_in[4]
    |-> ##[1:3] !irq_out) else $error("irq without enable");
  cover property (wake_out);
  cover property (irq_out);
  cover property (!timer_pin_avail_out);
  cover property (comparator_output_oe_out && comparator_output_pin_out);
endmodule
bind acec_top acec_props u_acec_props (.*);

// File: tb_top.sv
// testbench for the analog compare event control block
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic cmp_raw_in = 1'b0;
  logic timer_pin_in = 1'b0;
  acec_pkg::acec_pmode_t pmode_in = acec_pkg::PM_RUN;
  logic [7:0] rdata_out;
  logic analog_enable_out, reference_select_out, capture_in_out, timer_pin_avail_out;
  logic comparator_output_pin_out, comparator_output_oe_out, irq_out, wake_out;
  int fail_count = 0;
  int n_checks = 0;
  localparam logic [3:0] SC = acec_pkg::STATCTRL_OFF;
  always #2.5 clk_sys_in = ~clk_sys_in;
  acec_top u_acec_top (.*);
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 chk("rdata", e, rdata_out);
  endtask
  task automatic t_regs;
    rd(SC, acec_pkg::STATCTRL_RST);
    rd(4'hF, acec_pkg::UNMAPPED_RD);
    wr(SC, 8'hC0);
    cyc(2);
    chk("refsel", 8'h01, {7'h00, reference_select_out});
    rd(SC, 8'hC0);
    wr(SC, 8'h00);
    cmp_raw_in <= 1'b1;
    cyc(4);
    rd(SC, 8'h00);
    wr(SC, 8'h81);
    rd(SC, 8'h89);
    cmp_raw_in <= 1'b0;
    cyc(4);
    $display("regs done");
  endtask
  task automatic t_edges;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wr(SC, {6'h28, m});
      cyc(4);
      cmp_raw_in <= 1'b1;
      cyc(6);
      wr(SC, {6'h20, m});
      rd(SC, {2'b10, m[0], 3'b010, m});
      wr(SC, {6'h28, m});
      cmp_raw_in <= 1'b0;
      cyc(6);
      rd(SC, {2'b10, m != 2'h1, 3'b000, m});
    end
    $display("edges done");
  endtask
  task automatic t_irq;
    acec_pkg::acec_pmode_t pm[3] = '{acec_pkg::PM_WAIT, acec_pkg::PM_STOP3, acec_pkg::PM_BDM};
    foreach (pm[i]) begin
      wr(SC, 8'hB5);
      pmode_in <= pm[i];
      cyc(4);
      cmp_raw_in <= 1'b1;
      cyc(6);
      chk("irq", 8'h01, {7'h00, irq_out});
      chk("wake", {7'h00, pm[i] != acec_pkg::PM_BDM}, {7'h00, wake_out});
      chk("pin", 8'h03, {6'h00, comparator_output_oe_out, comparator_output_pin_out});
      rd(acec_pkg::PWRMODE_OFF, {5'h00, pm[i]});
      cmp_raw_in <= 1'b0;
      pmode_in <= acec_pkg::PM_RUN;
    end
    wr(SC, 8'h81);
    cyc(3);
    chk("irq", 8'h00, {7'h00, irq_out});
    rd(SC, 8'hA1);
    $display("irq done");
  endtask
  task automatic t_route;
    wr(SC, 8'hA0);
    cmp_raw_in <= 1'b1;
    wr(acec_pkg::SYSOPT_OFF, 8'h01);
    cyc(4);
    chk("route", 8'h01, {6'h00, timer_pin_avail_out, capture_in_out});
    chk("pin", 8'h00, {6'h00, comparator_output_oe_out, comparator_output_pin_out});
    wr(acec_pkg::SYSOPT_OFF, 8'h00);
    timer_pin_in <= 1'b1;
    cmp_raw_in <= 1'b0;
    cyc(4);
    chk("route", 8'h03, {6'h00, timer_pin_avail_out, capture_in_out});
    $display("route done");
  endtask
  task automatic t_stop;
    acec_pkg::acec_pmode_t pm[2] = '{acec_pkg::PM_STOP2, acec_pkg::PM_STOP1};
    foreach (pm[i]) begin
      wr(SC, 8'hD5);
      pmode_in <= pm[i];
      cyc(3);
      pmode_in <= acec_pkg::PM_RUN;
      rd(SC, 8'h00);
    end
    wr(SC, 8'hD5);
    pmode_in <= acec_pkg::PM_STOP3;
    cyc(2);
    nrst_in <= 1'b0;
    cyc(2);
    nrst_in <= 1'b1;
    pmode_in <= acec_pkg::PM_RUN;
    rd(SC, 8'h00);
    $display("stop done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    cyc(20);
    nrst_in <= 1'b1;
    t_regs;
    t_edges;
    t_irq;
    t_route;
    t_stop;
    end_of_test;
  end
  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end
endmodule
